// File: include/mclk_pkg.sv
// Constants for the master reference clock monitor and router.
// Assumes a 125 MHz core clock and a reference pin that is asynchronous to it.
package mclk_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CORE_CLK_MHZ = 125;
	// Detection interval without a reference edge, in microseconds
	localparam int STUCK_TIME_US = 10;
	localparam int STUCK_CYCLES = STUCK_TIME_US * CORE_CLK_MHZ;
	localparam int STUCK_CNT_W = 12;
	// Reference edges needed before the reference is declared running
	localparam int MIN_EDGES = 4;
	localparam int EDGE_CNT_W = 3;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [2:0] SYNC_RST = 3'h0;
	localparam logic [STUCK_CNT_W-1:0] STUCK_CNT_RST = 12'h000;
	localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_RST = 3'h0;

	typedef enum logic [1:0] {
		REF_ABSENT,
		REF_RUNNING,
		REF_STUCK_LOW,
		REF_STUCK_HIGH
	} ref_state_t;
endpackage

// File: rtl/mclk_monitor.sv
// Master reference clock monitor: detects a running, stuck-low or stuck-high
// reference and routes it to the receive, transmit and host timing consumers.
// Assumes the reference pin is asynchronous to core_clk_i and far slower.
`timescale 1ns/100ps
module mclk_monitor #(
	parameter int STUCK_CYCLES = mclk_pkg::STUCK_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic mclk_i,
	input wire logic tclk_i,
	input wire logic recovered_clk_i,
	input wire logic los_i,
	input wire logic blue_alarm_i,
	input wire logic rx_positive_rail_i,
	input wire logic rx_negative_rail_i,
	output logic ref_present_o,
	output logic ref_stuck_low_o,
	output logic ref_stuck_high_o,
	output logic cdr_ref_clk_o,
	output logic cdr_enable_o,
	output logic ja_enable_o,
	output logic all_ones_tx_generator_clk_o,
	output logic wait_state_clk_o,
	output logic wait_state_enable_o,
	output logic rx_power_down_o,
	output logic rx_clk_o,
	output logic rx_clk_oe_o,
	output logic rx_positive_rail_o,
	output logic rx_positive_rail_oe_o,
	output logic rx_negative_rail_o,
	output logic rx_negative_rail_oe_o
);
	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ****************************************
	// Reference synchroniser and edge detect
	// ****************************************
	logic [2:0] sync_q, sync_d;
	logic ref_level_q, ref_level_d;
	logic edge_seen;

	always_comb begin
		sync_d = {sync_q[1:0], mclk_i};
		ref_level_d = ref_level_q;
		if (sync_q[1] == sync_q[2]) begin
			ref_level_d = sync_q[2];
		end
	end
	assign edge_seen = (ref_level_d != ref_level_q);

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sync_q <= mclk_pkg::SYNC_RST;
			ref_level_q <= 1'b0;
		end else begin
			sync_q <= sync_d;
			ref_level_q <= ref_level_d;
		end
	end

	// ****************************************
	// Stuck detection
	// ****************************************
	localparam logic [mclk_pkg::STUCK_CNT_W-1:0] STUCK_LIMIT = mclk_pkg::STUCK_CNT_W'(STUCK_CYCLES - 1);
	localparam logic [mclk_pkg::EDGE_CNT_W-1:0] EDGE_LIMIT = mclk_pkg::EDGE_CNT_W'(mclk_pkg::MIN_EDGES - 1);
	logic [mclk_pkg::STUCK_CNT_W-1:0] idle_cnt_q, idle_cnt_d;
	logic [mclk_pkg::EDGE_CNT_W-1:0] edge_cnt_q, edge_cnt_d;
	mclk_pkg::ref_state_t state_q, state_d;

	always_comb begin
		idle_cnt_d = idle_cnt_q;
		edge_cnt_d = edge_cnt_q;
		state_d = state_q;
		if (edge_seen) begin
			idle_cnt_d = mclk_pkg::STUCK_CNT_RST;
			if (edge_cnt_q != EDGE_LIMIT) begin
				edge_cnt_d = edge_cnt_q + 1'b1;
			end
		end else if (idle_cnt_q != STUCK_LIMIT) begin
			idle_cnt_d = idle_cnt_q + 1'b1;
		end
		case (state_q)
			mclk_pkg::REF_ABSENT,
			mclk_pkg::REF_STUCK_LOW,
			mclk_pkg::REF_STUCK_HIGH: begin
				if (edge_seen && edge_cnt_q == EDGE_LIMIT) begin
					state_d = mclk_pkg::REF_RUNNING;
				end else if (!edge_seen && idle_cnt_q == STUCK_LIMIT) begin
					state_d = ref_level_q ? mclk_pkg::REF_STUCK_HIGH : mclk_pkg::REF_STUCK_LOW;
				end
			end
			mclk_pkg::REF_RUNNING: begin
				if (!edge_seen && idle_cnt_q == STUCK_LIMIT) begin
					state_d = ref_level_q ? mclk_pkg::REF_STUCK_HIGH : mclk_pkg::REF_STUCK_LOW;
					edge_cnt_d = mclk_pkg::EDGE_CNT_RST;
				end
			end
			default: begin
				state_d = mclk_pkg::REF_ABSENT;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt_q <= mclk_pkg::STUCK_CNT_RST;
			edge_cnt_q <= mclk_pkg::EDGE_CNT_RST;
			state_q <= mclk_pkg::REF_ABSENT;
		end else begin
			idle_cnt_q <= idle_cnt_d;
			edge_cnt_q <= edge_cnt_d;
			state_q <= state_d;
		end
	end

	// ****************************************
	// Clock routing and receive outputs
	// ****************************************
	logic running;
	logic rx_clk_q, rx_clk_d;
	logic rx_pos_q, rx_pos_d;
	logic rx_neg_q, rx_neg_d;
	logic rx_oe_q, rx_oe_d;

	assign running = (state_q == mclk_pkg::REF_RUNNING);

	always_comb begin
		rx_oe_d = (state_q != mclk_pkg::REF_STUCK_LOW);
		// Loss of signal keeps the receive clock alive from the reference
		rx_clk_d = (los_i && running) ? ref_level_q : recovered_clk_i;
		if (!running) begin
			// Front end only: no recovered clock is available, data passes straight except when the reference is stuck low
			rx_clk_d = 1'b0;
		end
		rx_pos_d = rx_positive_rail_i;
		rx_neg_d = rx_negative_rail_i;
		if (!rx_oe_d) begin
			rx_clk_d = 1'b0;
			rx_pos_d = 1'b0;
			rx_neg_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_clk_q <= 1'b0;
			rx_pos_q <= 1'b0;
			rx_neg_q <= 1'b0;
			rx_oe_q <= 1'b0;
		end else begin
			rx_clk_q <= rx_clk_d;
			rx_pos_q <= rx_pos_d;
			rx_neg_q <= rx_neg_d;
			rx_oe_q <= rx_oe_d;
		end
	end

	assign ref_present_o = running;
	assign ref_stuck_low_o = (state_q == mclk_pkg::REF_STUCK_LOW);
	assign ref_stuck_high_o = (state_q == mclk_pkg::REF_STUCK_HIGH);
	assign rx_power_down_o = ref_stuck_low_o;
	assign cdr_ref_clk_o = running & ref_level_q;
	assign cdr_enable_o = running;
	assign ja_enable_o = running;
	// Blue alarm timed from the reference; transmit clock otherwise
	assign all_ones_tx_generator_clk_o = blue_alarm_i ? (running & ref_level_q) : tclk_i;
	assign wait_state_clk_o = running & ref_level_q;
	assign wait_state_enable_o = running;
	assign rx_clk_o = rx_clk_q;
	assign rx_clk_oe_o = rx_oe_q;
	assign rx_positive_rail_o = rx_pos_q;
	assign rx_positive_rail_oe_o = rx_oe_q;
	assign rx_negative_rail_o = rx_neg_q;
	assign rx_negative_rail_oe_o = rx_oe_q;
endmodule // mclk_monitor

// File: testbench/mclk_monitor_checker.sv
// Checker for the reference clock monitor.
// Assumes one core clock and the active-low reset.
`timescale 1ns/100ps
module mclk_monitor_checker #(
	parameter int STUCK_CYCLES = 50
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic mclk_i,
	input wire logic blue_alarm_i,
	input wire logic ref_present_o,
	input wire logic ref_stuck_low_o,
	input wire logic ref_stuck_high_o,
	input wire logic cdr_enable_o,
	input wire logic ja_enable_o,
	input wire logic all_ones_tx_generator_clk_o,
	input wire logic wait_state_clk_o,
	input wire logic wait_state_enable_o,
	input wire logic rx_clk_o,
	input wire logic rx_clk_oe_o,
	input wire logic rx_positive_rail_oe_o,
	input wire logic rx_negative_rail_oe_o
);
	logic [15:0] idle_q, idle_d;
	logic mclk_q;
	// Cycles since the pin last changed, saturating
	always_comb begin
		idle_d = (mclk_i != mclk_q) ? 16'h0000 : idle_q + {15'h0000, idle_q != 16'hffff};
	end
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			idle_q <= 16'h0000;
			mclk_q <= 1'b0;
		end else begin
			idle_q <= idle_d;
			mclk_q <= mclk_i;
		end
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	a_low_float: assert property (ref_stuck_low_o && $past(ref_stuck_low_o) |->
		!(rx_clk_oe_o || rx_positive_rail_oe_o || rx_negative_rail_oe_o)) else $error("rx pins driven");
	a_high_no_cdr: assert property (ref_stuck_high_o |-> !cdr_enable_o && !ref_present_o) else $error("cdr on");
	a_cdr_ja_ref: assert property (cdr_enable_o == ref_present_o && ja_enable_o == ref_present_o) else $error("cdr");
	a_wait_ref: assert property (!ref_present_o |-> !wait_state_enable_o && !wait_state_clk_o) else $error("wait");
	a_alarm_ref: assert property (blue_alarm_i && !ref_present_o |-> !all_ones_tx_generator_clk_o) else $error("ones");
	a_rx_clk_idle: assert property (!ref_present_o [*2] |-> !rx_clk_o) else $error("rx clock runs");
	a_stuck_early: assert property ($rose(ref_stuck_low_o || ref_stuck_high_o) |-> idle_q >= STUCK_CYCLES)
		else $error("stuck too early");
	a_stuck_late: assert property (idle_q >= STUCK_CYCLES + 12 |-> ref_stuck_low_o || ref_stuck_high_o)
		else $error("stuck too late");
	c_run: cover property ($rose(ref_present_o));
	c_low: cover property ($rose(ref_stuck_low_o));
	c_high: cover property ($rose(ref_stuck_high_o));
endmodule // mclk_monitor_checker
bind mclk_monitor mclk_monitor_checker #(.STUCK_CYCLES(STUCK_CYCLES)) mclk_monitor_checker_inst (.*);

// File: testbench/mclk_source.sv
// Reference clock source model.
// Assumes run_i picks a running clock, else the pin holds hold_i.
`timescale 1ns/100ps
module mclk_source (
	input wire logic run_i,
	input wire logic hold_i,
	input wire logic e1_i,
	output logic mclk_o
);
	initial begin
		mclk_o = 1'b0;
		forever begin
			if (run_i) begin
				#(e1_i ? 244.1 : 323.8) mclk_o = ~mclk_o;
			end else begin
				#1 mclk_o = hold_i;
			end
		end
	end
endmodule // mclk_source

// File: testbench/testbench.sv
// Self-checking bench for the reference clock monitor.
// Assumes the source model and bound checker are compiled first.
`timescale 1ns/100ps
module testbench;
	logic core_clk_i = 1'b0, rstn_i = 1'b0, tclk_i = 1'b0, los_i = 1'b0, blue_alarm_i = 1'b0, recovered_clk_i = 1'b0;
	logic rx_positive_rail_i = 1'b1, rx_negative_rail_i = 1'b0, run = 1'b0, lvl = 1'b0, e1 = 1'b0, mclk_i;
	logic ref_present_o, ref_stuck_low_o, ref_stuck_high_o, cdr_ref_clk_o, cdr_enable_o, ja_enable_o;
	logic all_ones_tx_generator_clk_o, wait_state_clk_o, wait_state_enable_o, rx_power_down_o, rx_clk_o;
	logic rx_clk_oe_o, rx_positive_rail_o, rx_positive_rail_oe_o, rx_negative_rail_o, rx_negative_rail_oe_o;
	// Source mode, then present, low, high, power down, cdr, rx clock enable
	logic [8:0] rows [7] = '{9'h123, 9'h014, 9'h163, 9'h089, 9'h123, 9'h089, 9'h014};
	logic [2:0] prv;
	int tg [3];
	int err_count = 0, samples_checked = 0, cyc = 0;
	mclk_monitor #(.STUCK_CYCLES(50)) mclk_monitor_inst (.*);
	mclk_source mclk_source_inst (.run_i(run), .hold_i(lvl), .e1_i(e1), .mclk_o(mclk_i));
	initial forever #4 core_clk_i = ~core_clk_i;
	// Toggle counts sample on the falling edge, clear of the launching edge
	always @(negedge core_clk_i) begin
		tg[0] += int'(prv[0] !== rx_clk_o);
		tg[1] += int'(prv[1] !== all_ones_tx_generator_clk_o);
		tg[2] += int'(prv[2] !== wait_state_clk_o);
		prv = {wait_state_clk_o, all_ones_tx_generator_clk_o, rx_clk_o};
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic cmp(input logic [5:0] got, input logic [5:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic settle(input logic [2:0] st);
		for (int n = 0; n < 400 && {ref_present_o, ref_stuck_low_o, ref_stuck_high_o} !== st; n++) step(1);
		step(2);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		step(2);
		rstn_i = 1'b1;
		foreach (rows[i]) begin
			{run, lvl, e1} = rows[i][8:6];
			settle(rows[i][5:3]);
			cmp({ref_present_o, ref_stuck_low_o, ref_stuck_high_o, rx_power_down_o, cdr_enable_o, rx_clk_oe_o}, rows[i][5:0]);
			cmp({2'h0, ja_enable_o, rx_negative_rail_oe_o, rx_positive_rail_oe_o, rx_positive_rail_o}, {2'h0, rows[i][1], {3{rows[i][0]}}});
			$display("row %0d done", i);
		end
		run = 1'b1;
		settle(3'h4);
		{los_i, blue_alarm_i} = 2'h3;
		tg = '{0, 0, 0};
		step(300);
		cmp({3'h0, tg[0] > 2, tg[1] > 2, tg[2] > 2}, 6'h07);
		blue_alarm_i = 1'b0;
		tclk_i = 1'b1;
		step(1);
		cmp({5'h00, all_ones_tx_generator_clk_o}, 6'h01);
		$display("alarm and loss test done");
		{run, lvl, blue_alarm_i} = 3'h1;
		settle(3'h2);
		tg = '{0, 0, 0};
		step(100);
		cmp({3'h0, tg[0] > 0, tg[1] > 0, tg[2] > 0}, 6'h00);
		rstn_i = 1'b0;
		step(1);
		cmp({ref_present_o, ref_stuck_low_o, ref_stuck_high_o, rx_power_down_o, cdr_enable_o, rx_clk_oe_o}, 6'h00);
		$display("static and reset test done");
		tally_and_finish();
	end
endmodule // testbench
